// File: core/dmi_pkg.sv
// Package: data memory map, widths and operation codes
package dmi_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_WINDOW_0 = 8'h00;
    localparam logic [7:0] ADDR_POINTER_0 = 8'h01;
    localparam logic [7:0] ADDR_WINDOW_1 = 8'h02;
    localparam logic [7:0] ADDR_POINTER_1 = 8'h03;
    localparam logic [7:0] ADDR_ACCUM = 8'h05;
    localparam logic [7:0] SFR_LAST = 8'h3F;
    localparam logic [7:0] GPR_FIRST = 8'h40;
    localparam logic [7:0] GPR_LAST = 8'hFF;
    localparam int GPR_DEPTH = 192;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    // Memory operation codes issued by the core
    typedef enum logic [2:0] {
        DMI_OP_NONE = 3'b000,
        DMI_OP_WRITE = 3'b001,
        DMI_OP_BSET = 3'b010,
        DMI_OP_BCLR = 3'b011,
        DMI_OP_INC = 3'b100,
        DMI_OP_DEC = 3'b101
    } dmi_op_e;
endpackage : dmi_pkg

// File: core/dmi_data_memory.sv
// Data memory with indirect windows, pointers and accumulator
`timescale 1ns/1ps
module dmi_data_memory
    import dmi_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Memory access from the core
    input wire logic [7:0] mem_addr_i,
    input wire dmi_op_e mem_op_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic [2:0] mem_bit_i,
    output logic [7:0] mem_rdata_o,
    output logic [7:0] mem_eff_addr_o,
    // Accumulator from the ALU
    input wire logic acc_load_i,
    input wire logic [7:0] acc_data_i,
    output logic [7:0] acc_o,
    // Read-only special locations held elsewhere
    input wire logic [7:0] ro_mask_lo_i,
    output logic ro_hit_o
);
    logic [7:0] gpr_mem [GPR_DEPTH];
    logic [7:0] pointer_0;
    logic [7:0] pointer_1;
    logic [7:0] accum;
    logic [7:0] next_pointer_0;
    logic [7:0] next_pointer_1;
    logic [7:0] next_accum;
    logic [7:0] eff_addr;
    logic [7:0] cur_val;
    logic [7:0] new_val;
    logic do_write;
    logic is_gpr;
    logic is_ro;
    logic [7:0] gpr_idx;

    // Windows redirect through their paired pointer
    always_comb begin
        if (mem_addr_i == ADDR_WINDOW_0) begin
            eff_addr = pointer_0;
        end else if (mem_addr_i == ADDR_WINDOW_1) begin
            eff_addr = pointer_1;
        end else begin
            eff_addr = mem_addr_i;
        end
    end

    assign is_gpr = (eff_addr >= GPR_FIRST);
    assign gpr_idx = eff_addr - GPR_FIRST;
    // Low special addresses 08H..0FH may be flagged read-only by the map
    assign is_ro = (eff_addr[7:3] == 5'h01) && ro_mask_lo_i[eff_addr[2:0]];

    // Current value of the resolved location
    always_comb begin
        cur_val = READ_ZERO;
        if (is_gpr) begin
            cur_val = gpr_mem[gpr_idx];
        end else begin
            case (eff_addr)
                ADDR_POINTER_0: cur_val = pointer_0;
                ADDR_POINTER_1: cur_val = pointer_1;
                ADDR_ACCUM: cur_val = accum;
                default: cur_val = READ_ZERO;
            endcase
        end
    end

    // Value to store for the requested operation
    always_comb begin
        new_val = cur_val;
        do_write = 1'b1;
        case (mem_op_i)
            DMI_OP_WRITE: new_val = mem_wdata_i;
            DMI_OP_BSET: begin
                new_val = cur_val | (ONE_BYTE << mem_bit_i);
            end
            DMI_OP_BCLR: begin
                new_val = cur_val & ~(ONE_BYTE << mem_bit_i);
            end
            DMI_OP_INC: new_val = cur_val + ONE_BYTE;
            DMI_OP_DEC: new_val = cur_val - ONE_BYTE;
            default: do_write = 1'b0;
        endcase
        if (is_ro) begin
            do_write = 1'b0;
        end
    end

    // Register next values; ALU load has priority over a memory write
    always_comb begin
        next_pointer_0 = pointer_0;
        next_pointer_1 = pointer_1;
        next_accum = accum;
        if (do_write && !is_gpr) begin
            case (eff_addr)
                ADDR_POINTER_0: next_pointer_0 = new_val;
                ADDR_POINTER_1: next_pointer_1 = new_val;
                ADDR_ACCUM: next_accum = new_val;
                default: next_accum = accum;
            endcase
        end
        if (acc_load_i) begin
            next_accum = acc_data_i;
        end
    end

    // Pointers reset to zero so a stray window access stays predictable
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pointer_0 <= RESET_VALUE;
            pointer_1 <= RESET_VALUE;
            accum <= RESET_VALUE;
        end else begin
            pointer_0 <= next_pointer_0;
            pointer_1 <= next_pointer_1;
            accum <= next_accum;
        end
    end

    // RAM has no reset; software initialises it first
    always_ff @(posedge clk_i) begin
        if (do_write && is_gpr) begin
            gpr_mem[gpr_idx] <= new_val;
        end
    end

    assign mem_rdata_o = cur_val;
    assign mem_eff_addr_o = eff_addr;
    assign acc_o = accum;
    assign ro_hit_o = is_ro;

    property p_win0_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_WINDOW_0 && pointer_0 == ADDR_WINDOW_0)
            |-> mem_rdata_o == READ_ZERO;
    endproperty
    a_win0_read: assert property (p_win0_read)
        else $error("window self read not zero");

    property p_win_redirect;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_WINDOW_1) |-> mem_eff_addr_o == pointer_1;
    endproperty
    a_win_redirect: assert property (p_win_redirect)
        else $error("window 1 not redirected");

    property p_acc_load;
        @(posedge clk_i) disable iff (!resetn_i)
        acc_load_i |=> acc_o == $past(acc_data_i);
    endproperty
    a_acc_load: assert property (p_acc_load)
        else $error("accumulator missed ALU result");

    property p_unused_zero;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == 8'h04 || mem_addr_i == 8'h3E)
            |-> mem_rdata_o == READ_ZERO;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused special address not zero");

    property p_inc_ptr0;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_POINTER_0 && mem_op_i == DMI_OP_INC)
            |=> pointer_0 == $past(pointer_0) + ONE_BYTE;
    endproperty
    a_inc_ptr0: assert property (p_inc_ptr0)
        else $error("pointer 0 increment failed");

    property p_bset_acc;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_ACCUM && mem_op_i == DMI_OP_BSET && !acc_load_i)
            |=> acc_o == ($past(acc_o) | (ONE_BYTE << $past(mem_bit_i)));
    endproperty
    a_bset_acc: assert property (p_bset_acc)
        else $error("bit set changed other bits");

    property p_gpr_back;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_op_i == DMI_OP_WRITE && mem_addr_i >= GPR_FIRST)
            ##1 (mem_op_i == DMI_OP_NONE && mem_addr_i == $past(mem_addr_i))
            |-> mem_rdata_o == $past(mem_wdata_i);
    endproperty
    a_gpr_back: assert property (p_gpr_back)
        else $error("RAM write not read back");

    property p_ptr1_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_op_i == DMI_OP_NONE) |=> $stable(pointer_1);
    endproperty
    a_ptr1_hold: assert property (p_ptr1_hold)
        else $error("pointer 1 changed without write");

    property p_win0_redirect;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_WINDOW_0) |-> mem_eff_addr_o == pointer_0;
    endproperty
    a_win0_redirect: assert property (p_win0_redirect)
        else $error("window 0 not redirected");

    property p_direct_addr;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i != ADDR_WINDOW_0 && mem_addr_i != ADDR_WINDOW_1)
            |-> mem_eff_addr_o == mem_addr_i;
    endproperty
    a_direct_addr: assert property (p_direct_addr)
        else $error("direct address altered");

    property p_win_nested_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_WINDOW_0 || mem_addr_i == ADDR_WINDOW_1) &&
        (mem_eff_addr_o == ADDR_WINDOW_0 || mem_eff_addr_o == ADDR_WINDOW_1)
            |-> mem_rdata_o == READ_ZERO;
    endproperty
    a_win_nested_read: assert property (p_win_nested_read)
        else $error("window to window read not zero");

    // A window aimed at a window must not fall through to a pointer
    property p_win_nested_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_op_i != DMI_OP_NONE) &&
        (mem_eff_addr_o == ADDR_WINDOW_0 || mem_eff_addr_o == ADDR_WINDOW_1)
            |=> $stable(pointer_0) && $stable(pointer_1);
    endproperty
    a_win_nested_write: assert property (p_win_nested_write)
        else $error("write through window changed a pointer");

    property p_ptr0_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_POINTER_0 && mem_op_i == DMI_OP_WRITE)
            |=> pointer_0 == $past(mem_wdata_i);
    endproperty
    a_ptr0_write: assert property (p_ptr0_write)
        else $error("pointer 0 write lost");

    property p_ptr1_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_POINTER_1 && mem_op_i == DMI_OP_WRITE)
            |=> pointer_1 == $past(mem_wdata_i);
    endproperty
    a_ptr1_write: assert property (p_ptr1_write)
        else $error("pointer 1 write lost");

    property p_dec_ptr1;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_POINTER_1 && mem_op_i == DMI_OP_DEC)
            |=> pointer_1 == $past(pointer_1) - ONE_BYTE;
    endproperty
    a_dec_ptr1: assert property (p_dec_ptr1)
        else $error("pointer 1 decrement failed");

    property p_acc_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_ACCUM && mem_op_i == DMI_OP_WRITE && !acc_load_i)
            |=> acc_o == $past(mem_wdata_i);
    endproperty
    a_acc_write: assert property (p_acc_write)
        else $error("accumulator write lost");

    property p_acc_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_ACCUM) |-> mem_rdata_o == acc_o;
    endproperty
    a_acc_read: assert property (p_acc_read)
        else $error("accumulator read mismatch");

    property p_ptr1_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_POINTER_1) |-> mem_rdata_o == pointer_1;
    endproperty
    a_ptr1_read: assert property (p_ptr1_read)
        else $error("pointer 1 read mismatch");

    property p_sfr_unused;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_eff_addr_o <= SFR_LAST && mem_eff_addr_o != ADDR_POINTER_0 &&
        mem_eff_addr_o != ADDR_POINTER_1 && mem_eff_addr_o != ADDR_ACCUM)
            |-> mem_rdata_o == READ_ZERO;
    endproperty
    a_sfr_unused: assert property (p_sfr_unused)
        else $error("special location without storage not zero");

    property p_bclr_ram;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_op_i == DMI_OP_BCLR && mem_addr_i >= GPR_FIRST) ##1
        (mem_op_i == DMI_OP_NONE && mem_addr_i == $past(mem_addr_i))
            |-> mem_rdata_o ==
            ($past(mem_rdata_o) & ~(ONE_BYTE << $past(mem_bit_i)));
    endproperty
    a_bclr_ram: assert property (p_bclr_ram)
        else $error("bit clear changed other bits");

    property p_ro_range;
        @(posedge clk_i) disable iff (!resetn_i)
        ro_hit_o |-> (mem_eff_addr_o >= 8'h08 && mem_eff_addr_o <= 8'h0F);
    endproperty
    a_ro_range: assert property (p_ro_range)
        else $error("read-only flag outside its range");

    property p_ro_no_change;
        @(posedge clk_i) disable iff (!resetn_i)
        (ro_hit_o && mem_op_i != DMI_OP_NONE && !acc_load_i)
            |=> $stable(pointer_0) && $stable(pointer_1) && $stable(acc_o);
    endproperty
    a_ro_no_change: assert property (p_ro_no_change)
        else $error("read-only write changed storage");

    property p_ptr0_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_op_i == DMI_OP_NONE) |=> $stable(pointer_0);
    endproperty
    a_ptr0_hold: assert property (p_ptr0_hold)
        else $error("pointer 0 changed without write");

    property p_win0_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (mem_addr_i == ADDR_WINDOW_0 && mem_op_i == DMI_OP_WRITE &&
        pointer_0 >= GPR_FIRST) ##1
        (mem_op_i == DMI_OP_NONE && mem_addr_i == $past(pointer_0))
            |-> mem_rdata_o == $past(mem_wdata_i);
    endproperty
    a_win0_write: assert property (p_win0_write)
        else $error("window write missed pointed location");

    c_win0_write: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mem_addr_i == ADDR_WINDOW_0 && mem_op_i == DMI_OP_WRITE && is_gpr);
    c_ro_block: cover property (@(posedge clk_i) disable iff (!resetn_i)
        ro_hit_o && mem_op_i == DMI_OP_WRITE);
    c_acc_move: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mem_addr_i == ADDR_ACCUM && mem_op_i == DMI_OP_WRITE ##1
        mem_addr_i >= GPR_FIRST && mem_op_i == DMI_OP_WRITE);
    c_ptr_step: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mem_addr_i == ADDR_POINTER_0 && mem_op_i == DMI_OP_INC);
    c_win_nested: cover property (@(posedge clk_i) disable iff (!resetn_i)
        mem_op_i != DMI_OP_NONE && mem_eff_addr_o == ADDR_WINDOW_0);
endmodule : dmi_data_memory

// File: bench/dmi_core_model.sv
// Core model issuing memory operations and accumulator loads
`timescale 1ns/1ps
module dmi_core_model
    import dmi_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Memory access
    output logic [7:0] mem_addr_o,
    output dmi_op_e mem_op_o,
    output logic [7:0] mem_wdata_o,
    output logic [2:0] mem_bit_o,
    // Accumulator load
    output logic acc_load_o,
    output logic [7:0] acc_data_o
);
    initial begin
        {mem_addr_o, mem_wdata_o, mem_bit_o, acc_data_o} = 27'h0;
        acc_load_o = 1'b0;
        mem_op_o = DMI_OP_NONE;
    end
    // Each call replaces the previous request; a read leaves the bus idle
    task automatic issue(input logic [7:0] a, input dmi_op_e op,
                         input logic [7:0] d, input logic [2:0] b);
        mem_addr_o = a;
        mem_op_o = op;
        mem_wdata_o = d;
        mem_bit_o = b;
        @(posedge clk_i);
        #1;
    endtask : issue
    task automatic load_acc(input logic [7:0] d);
        acc_load_o = 1'b1;
        acc_data_o = d;
        @(posedge clk_i);
        #1;
        acc_load_o = 1'b0;
        acc_data_o = ~d;
    endtask : load_acc
endmodule : dmi_core_model

// File: bench/data_memory_indirect_access_tb_top.sv
// Self-checking bench for the data memory block
`timescale 1ns/1ps
module data_memory_indirect_access_tb_top;
    import dmi_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] ro_mask = 8'h00;
    logic [7:0] addr, wdata, rdata, eff, accd, acc;
    logic [2:0] bitn;
    logic ld, ro_hit;
    dmi_op_e op;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 clk_i = ~clk_i;
    dmi_core_model core_u (.clk_i(clk_i), .mem_addr_o(addr),
        .mem_op_o(op), .mem_wdata_o(wdata), .mem_bit_o(bitn),
        .acc_load_o(ld), .acc_data_o(accd));
    dmi_data_memory dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
        .mem_addr_i(addr), .mem_op_i(op), .mem_wdata_i(wdata),
        .mem_bit_i(bitn), .mem_rdata_o(rdata), .mem_eff_addr_o(eff),
        .acc_load_i(ld), .acc_data_i(accd), .acc_o(acc),
        .ro_mask_lo_i(ro_mask), .ro_hit_o(ro_hit));
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core_u.issue(a, DMI_OP_WRITE, d, 3'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        core_u.issue(a, DMI_OP_NONE, 8'h00, 3'h0);
        chk(rdata, e);
    endtask : rd
    task automatic t_gpr();
        wr(8'h40, 8'hA5);
        wr(8'hFF, 8'h5A);
        rd(8'h40, 8'hA5);
        rd(8'hFF, 8'h5A);
    endtask : t_gpr
    task automatic t_bits();
        wr(8'h41, 8'h0F);
        core_u.issue(8'h41, DMI_OP_BSET, 8'h00, 3'h7);
        core_u.issue(8'h41, DMI_OP_BCLR, 8'h00, 3'h0);
        rd(8'h41, 8'h8E);
    endtask : t_bits
    task automatic t_indirect();
        rd(8'h00, 8'h00);
        wr(8'h01, 8'h42);
        wr(8'h00, 8'h55);
        rd(8'h42, 8'h55);
        rd(8'h00, 8'h55);
        chk(eff, 8'h42);
        core_u.issue(8'h01, DMI_OP_INC, 8'h00, 3'h0);
        wr(8'h00, 8'h66);
        rd(8'h43, 8'h66);
        wr(8'h03, 8'hFE);
        core_u.issue(8'h03, DMI_OP_INC, 8'h00, 3'h0);
        rd(8'h03, 8'hFF);
        rd(8'h02, 8'h5A);
        chk(eff, 8'hFF);
        core_u.issue(8'h03, DMI_OP_DEC, 8'h00, 3'h0);
        wr(8'h02, 8'h77);
        rd(8'hFE, 8'h77);
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h33);
        rd(8'h02, 8'h00);
    endtask : t_indirect
    task automatic t_sfr();
        rd(8'h04, 8'h00);
        ro_mask = 8'h01;
        rd(8'h08, 8'h00);
        chk({7'h0, ro_hit}, 8'h01);
        wr(8'h08, 8'h99);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        chk({7'h0, ro_hit}, 8'h00);
        ro_mask = 8'h00;
    endtask : t_sfr
    task automatic t_acc();
        core_u.load_acc(8'h3C);
        chk(acc, 8'h3C);
        rd(8'h05, 8'h3C);
        wr(8'h05, 8'hA5);
        wr(8'h43, acc);
        rd(8'h43, 8'hA5);
        core_u.issue(8'h05, DMI_OP_BSET, 8'h00, 3'h1);
        rd(8'h05, 8'hA7);
    endtask : t_acc
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 400) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk(acc, 8'h00);
        t_gpr();
        t_bits();
        t_indirect();
        t_sfr();
        t_acc();
        stop_test();
    end
endmodule : data_memory_indirect_access_tb_top
